/* hdl/fpu_classify_exchange_extract_log.sv */
// Stack unit executing classify, exchange, extract and log-multiply instructions.
`timescale 1ns/1ns
`default_nettype none
module fpu_classify_exchange_extract_log (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Instruction
  input wire logic op_valid,
  input wire logic [7:0] op_byte0,
  input wire logic [7:0] op_byte1,
  // Control
  input wire logic emulation_flag,
  input wire logic task_switched_flag,
  input wire logic invalid_mask,
  input wire logic zero_divide_mask,
  input wire logic denormal_mask,
  // Stack load and read
  input wire logic load_valid,
  input wire logic [2:0] load_index,
  input wire logic load_full,
  input wire logic [79:0] load_data,
  input wire logic [2:0] read_index,
  output logic [79:0] read_data_q,
  output logic read_full_q,
  // Status
  output logic condition_bit_zero_q,
  output logic condition_bit_one_q,
  output logic condition_bit_two_q,
  output logic condition_bit_three_q,
  output logic [2:0] stack_pointer_field_q,
  output logic op_done_q,
  // Fault pulses
  output logic device_unavailable_fault_q,
  output logic stack_fault_q,
  output logic invalid_operand_fault_q,
  output logic divide_by_zero_fault_q,
  output logic denormal_operand_fault_q
);
  // ****************************************************************
  // Stack storage and operand selection
  // ****************************************************************
  logic [79:0] stack_q [8];
  logic [7:0] tag_full_q;
  logic [2:0] p0, p1, pi, pm;
  logic [79:0] st0, st1, sti, lg_prod;
  fpu_xel_pkg::value_class_t cls0, cls1;
  logic snan0, snan1;
  logic is_cls, is_xch, is_ext, is_log, blocked;

  assign p0 = stack_pointer_field_q;
  assign p1 = stack_pointer_field_q + 3'h1;
  assign pi = stack_pointer_field_q + op_byte1[2:0];
  assign pm = stack_pointer_field_q - 3'h1;
  assign st0 = stack_q[p0];
  assign st1 = stack_q[p1];
  assign sti = stack_q[pi];
  assign blocked = emulation_flag || task_switched_flag;
  assign is_cls = op_byte0 == fpu_xel_pkg::OPC_ESC && op_byte1 == fpu_xel_pkg::OPC_CLASSIFY;
  assign is_xch = op_byte0 == fpu_xel_pkg::OPC_ESC && op_byte1[7:3] == fpu_xel_pkg::OPC_XCH_BASE[7:3];
  assign is_ext = op_byte0 == fpu_xel_pkg::OPC_ESC && op_byte1 == fpu_xel_pkg::OPC_EXTRACT;
  assign is_log = op_byte0 == fpu_xel_pkg::OPC_ESC && op_byte1 == fpu_xel_pkg::OPC_LOG_MUL;

  fp_class_unit u_cls0 (.value(st0), .full(tag_full_q[p0]), .cls(cls0), .is_snan(snan0));
  fp_class_unit u_cls1 (.value(st1), .full(tag_full_q[p1]), .cls(cls1), .is_snan(snan1));
  log2_mul_unit u_log (.x(st0), .y(st1), .prod(lg_prod));

  // Integer exponent to extended real; the shift normalises the magnitude.
  function automatic logic [79:0] int_to_ext(input logic [16:0] e);
    logic [15:0] mag;
    logic [6:0] lz;
    mag = e[16] ? 16'(17'h0 - e) : e[15:0];
    lz = fpu_xel_pkg::lead_zeros({mag, 48'h0});
    if (mag == 16'h0)
      return fpu_xel_pkg::POS_ZERO;
    return {e[16], 15'(fpu_xel_pkg::EXP_BIAS + 15'h000F - {8'h0, lz}), {mag, 48'h0} << lz};
  endfunction : int_to_ext

  // ****************************************************************
  // Instruction execution
  // ****************************************************************
  logic wa_en, wb_en, wa_full, wb_full, c1_en, c1_val, cls_en;
  logic [2:0] wa_idx, wb_idx, top_d;
  logic [79:0] wa_val, wb_val;
  logic dna_d, sf_d, ia_d, z_d, d_d, commit;
  logic [6:0] slz;
  logic [16:0] true_exp;

  assign slz = fpu_xel_pkg::lead_zeros(st0[63:0]);
  assign true_exp = (cls0 == fpu_xel_pkg::CLS_DENORMAL)
                  ? fpu_xel_pkg::DENORM_TRUE_EXP - {10'h0, slz}
                  : {2'h0, st0[78:64]} - {2'h0, fpu_xel_pkg::EXP_BIAS};

  always_comb
  begin
    wa_en = 1'b0; wb_en = 1'b0; wa_full = 1'b1; wb_full = 1'b1;
    wa_idx = p0; wb_idx = p1; wa_val = st0; wb_val = st1;
    top_d = stack_pointer_field_q;
    c1_en = 1'b0; c1_val = 1'b0; cls_en = 1'b0;
    dna_d = 1'b0; sf_d = 1'b0; ia_d = 1'b0; z_d = 1'b0; d_d = 1'b0;
    commit = 1'b0;
    if (op_valid && blocked)
      dna_d = 1'b1;
    else if (op_valid && is_cls)
      cls_en = 1'b1;
    else if (op_valid && is_xch)
    begin
      c1_en = 1'b1;
      sf_d = !tag_full_q[p0] || !tag_full_q[pi];
      commit = !sf_d || invalid_mask;
      wa_en = commit; wa_val = tag_full_q[pi] ? sti : fpu_xel_pkg::QNAN_INDEF;
      wb_en = commit; wb_idx = pi; wb_val = tag_full_q[p0] ? st0 : fpu_xel_pkg::QNAN_INDEF;
    end
    else if (op_valid && is_ext)
    begin
      wb_idx = pm;
      if (!tag_full_q[p0] || tag_full_q[pm])
      begin
        sf_d = 1'b1; c1_en = 1'b1; c1_val = tag_full_q[p0];
        wa_val = fpu_xel_pkg::QNAN_INDEF; wb_val = fpu_xel_pkg::QNAN_INDEF;
        commit = invalid_mask;
      end
      else
      begin
        wb_val = {st0[79], fpu_xel_pkg::EXP_BIAS, st0[63:0] << slz};
        wa_val = int_to_ext(true_exp);
        case (cls0)
          fpu_xel_pkg::CLS_UNSUPPORTED, fpu_xel_pkg::CLS_NAN:
          begin
            ia_d = (cls0 == fpu_xel_pkg::CLS_UNSUPPORTED) || snan0;
            wa_val = ia_d ? fpu_xel_pkg::QNAN_INDEF : (st0 | 80'h4000_0000_0000_0000);
            wb_val = wa_val;
            commit = !ia_d || invalid_mask;
          end
          fpu_xel_pkg::CLS_ZERO:
          begin
            z_d = 1'b1; wa_val = fpu_xel_pkg::NEG_INF; wb_val = st0;
            commit = zero_divide_mask;
          end
          fpu_xel_pkg::CLS_INF:
          begin
            wa_val = fpu_xel_pkg::POS_INF; wb_val = st0; commit = 1'b1;
          end
          fpu_xel_pkg::CLS_DENORMAL:
          begin
            d_d = 1'b1; commit = denormal_mask;
          end
          default: commit = 1'b1;
        endcase
      end
      // exponent in old top, push significand
      wa_en = commit; wb_en = commit;
      top_d = commit ? pm : stack_pointer_field_q;
    end
    else if (op_valid && is_log)
    begin
      wa_full = 1'b0;
      wb_val = lg_prod;
      if (!tag_full_q[p0] || !tag_full_q[p1])
      begin
        sf_d = 1'b1; c1_en = 1'b1; ia_d = 1'b0;
        wb_val = fpu_xel_pkg::QNAN_INDEF;
      end
      else if (cls0 == fpu_xel_pkg::CLS_NAN || cls1 == fpu_xel_pkg::CLS_NAN
               || cls0 == fpu_xel_pkg::CLS_UNSUPPORTED || cls1 == fpu_xel_pkg::CLS_UNSUPPORTED)
      begin
        ia_d = snan0 || snan1 || cls0 == fpu_xel_pkg::CLS_UNSUPPORTED
               || cls1 == fpu_xel_pkg::CLS_UNSUPPORTED;
        wb_val = ((cls0 == fpu_xel_pkg::CLS_NAN) ? st0 : st1) | 80'h4000_0000_0000_0000;
      end
      else if (st0[79] && cls0 != fpu_xel_pkg::CLS_ZERO)
        ia_d = 1'b1;
      else if (cls0 == fpu_xel_pkg::CLS_ZERO)
      begin
        ia_d = cls1 == fpu_xel_pkg::CLS_ZERO;
        z_d = cls1 == fpu_xel_pkg::CLS_NORMAL || cls1 == fpu_xel_pkg::CLS_DENORMAL;
        wb_val = st1[79] ? fpu_xel_pkg::POS_INF : fpu_xel_pkg::NEG_INF;
      end
      else if (cls0 == fpu_xel_pkg::CLS_INF)
      begin
        // infinite top follows sign of next
        ia_d = cls1 == fpu_xel_pkg::CLS_ZERO;
        wb_val = st1[79] ? fpu_xel_pkg::NEG_INF : fpu_xel_pkg::POS_INF;
      end
      else
      begin
        d_d = cls0 == fpu_xel_pkg::CLS_DENORMAL || cls1 == fpu_xel_pkg::CLS_DENORMAL;
        if (cls1 == fpu_xel_pkg::CLS_ZERO)
          wb_val = fpu_xel_pkg::POS_ZERO;
        else if (cls1 == fpu_xel_pkg::CLS_INF)
          wb_val = (st1[79] ^ (st0[78:64] < fpu_xel_pkg::EXP_BIAS))
                 ? fpu_xel_pkg::NEG_INF : fpu_xel_pkg::POS_INF;
      end
      if (ia_d)
        wb_val = fpu_xel_pkg::QNAN_INDEF;
      commit = ((sf_d || ia_d) ? invalid_mask : 1'b1) && (!z_d || zero_divide_mask)
               && (!d_d || denormal_mask);
      wa_en = commit; wb_en = commit;
      top_d = commit ? p1 : stack_pointer_field_q;
    end
  end

  // ****************************************************************
  // State update
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      tag_full_q <= 8'h00;
    else if (wa_en || wb_en)
    begin
      if (wa_en)
        tag_full_q[wa_idx] <= wa_full;
      if (wb_en)
        tag_full_q[wb_idx] <= wb_full;
    end
    else if (load_valid && !op_valid)
      tag_full_q[3'(stack_pointer_field_q + load_index)] <= load_full;
  end

  // Register contents carry no reset; only the tags decide validity.
  always_ff @(posedge mclk)
  begin
    if (wa_en)
      stack_q[wa_idx] <= wa_val;
    if (wb_en)
      stack_q[wb_idx] <= wb_val;
    if (load_valid && !op_valid)
      stack_q[3'(stack_pointer_field_q + load_index)] <= load_data;
  end

  // pointer moves on push and pop
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      stack_pointer_field_q <= 3'h0;
    else
      stack_pointer_field_q <= top_d;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      condition_bit_zero_q <= 1'b0;
      condition_bit_two_q <= 1'b0;
      condition_bit_three_q <= 1'b0;
      condition_bit_one_q <= 1'b0;
    end
    else if (cls_en)
    begin
      {condition_bit_three_q, condition_bit_two_q, condition_bit_zero_q} <= cls0;
      condition_bit_one_q <= st0[fpu_xel_pkg::SIGN_POS];
    end
    else if (c1_en)
      condition_bit_one_q <= c1_val;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      op_done_q <= 1'b0;
      device_unavailable_fault_q <= 1'b0;
      stack_fault_q <= 1'b0;
      invalid_operand_fault_q <= 1'b0;
      divide_by_zero_fault_q <= 1'b0;
      denormal_operand_fault_q <= 1'b0;
    end
    else
    begin
      op_done_q <= op_valid;
      device_unavailable_fault_q <= dna_d;
      stack_fault_q <= sf_d;
      invalid_operand_fault_q <= ia_d;
      divide_by_zero_fault_q <= z_d;
      denormal_operand_fault_q <= d_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    read_data_q <= stack_q[3'(stack_pointer_field_q + read_index)];
    read_full_q <= tag_full_q[3'(stack_pointer_field_q + read_index)];
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_go(logic hit);
    op_valid && !blocked && hit;
  endsequence
  sequence s_unmasked;
    (invalid_operand_fault_q && !invalid_mask) || (divide_by_zero_fault_q && !zero_divide_mask)
    || (denormal_operand_fault_q && !denormal_mask);
  endsequence

  AST_CLASS_CODE: assert property (s_go(is_cls) |=>
    {condition_bit_three_q, condition_bit_two_q, condition_bit_zero_q} == $past(cls0))
    else $error("classify code mismatch");
  AST_CLASS_SIGN: assert property (s_go(is_cls) |=>
    condition_bit_one_q == $past(st0[79]))
    else $error("classify sign mismatch");
  AST_CLASS_KEEP: assert property (s_go(is_cls) |=>
    $stable(stack_pointer_field_q) && $stable(tag_full_q) && !stack_fault_q)
    else $error("classify changed stack");
  AST_BLOCKED: assert property (op_valid && blocked |=>
    device_unavailable_fault_q && $stable(stack_pointer_field_q) && $stable(tag_full_q))
    else $error("blocked instruction executed");
  AST_XCH_C1: assert property (s_go(is_xch) |=> !condition_bit_one_q)
    else $error("exchange left bit one set");
  AST_XCH_UNDER: assert property (s_go(is_xch) && !tag_full_q[pi] |=> stack_fault_q)
    else $error("exchange underflow not flagged");
  AST_EXT_PUSH: assert property (s_go(is_ext) && commit |=>
    stack_pointer_field_q == 3'($past(stack_pointer_field_q) - 3'h1) && tag_full_q[stack_pointer_field_q])
    else $error("extract did not push");
  AST_EXT_SIG: assert property (s_go(is_ext) && cls0 == fpu_xel_pkg::CLS_NORMAL && !tag_full_q[pm] |=>
    stack_q[stack_pointer_field_q][78:64] == fpu_xel_pkg::EXP_BIAS)
    else $error("significand exponent wrong");
  AST_EXT_OVER: assert property (s_go(is_ext) && tag_full_q[p0] && tag_full_q[pm] |=>
    stack_fault_q && condition_bit_one_q)
    else $error("extract overflow not flagged");
  AST_LOG_POP: assert property (s_go(is_log) && commit |=>
    stack_pointer_field_q == 3'($past(stack_pointer_field_q) + 3'h1) && !tag_full_q[$past(p0)])
    else $error("log multiply did not pop");
  AST_HOLD: assert property (op_valid ##1 s_unmasked |->
    stack_pointer_field_q == $past(stack_pointer_field_q) && tag_full_q == $past(tag_full_q))
    else $error("unmasked fault changed stack");
endmodule : fpu_classify_exchange_extract_log
`default_nettype wire

/* hdl/fpu_xel_pkg.sv */
// Shared constants, value classes and the leading-zero helper function for the stack instruction unit.
package fpu_xel_pkg;

  // ****************************************************************
  // Extended-real layout
  // ****************************************************************
  localparam int EXT_W = 80;
  localparam int SIGN_POS = 79;
  localparam int EXP_HI = 78;
  localparam int EXP_LO = 64;
  localparam int INT_POS = 63;
  localparam int QUIET_POS = 62;
  localparam int LOG_FRAC_W = 16;
  localparam logic [14:0] EXP_BIAS = 15'h3FFF;
  localparam logic [14:0] EXP_MAX = 15'h7FFF;
  localparam logic [14:0] EXP_ZERO = 15'h0000;
  localparam logic [16:0] DENORM_TRUE_EXP = 17'h1C002;
  localparam logic [79:0] QNAN_INDEF = 80'hFFFF_C000_0000_0000_0000;
  localparam logic [79:0] POS_INF = 80'h7FFF_8000_0000_0000_0000;
  localparam logic [79:0] NEG_INF = 80'hFFFF_8000_0000_0000_0000;
  localparam logic [79:0] POS_ZERO = 80'h0000_0000_0000_0000_0000;

  // ****************************************************************
  // Opcode bytes
  // ****************************************************************
  localparam logic [7:0] OPC_ESC = 8'hD9;
  localparam logic [7:0] OPC_CLASSIFY = 8'hE5;
  localparam logic [7:0] OPC_XCH_BASE = 8'hC8;
  localparam logic [7:0] OPC_EXTRACT = 8'hF4;
  localparam logic [7:0] OPC_LOG_MUL = 8'hF1;

  // ****************************************************************
  // Value classes, coded as the condition bits three, two and zero
  // ****************************************************************
  typedef enum logic [2:0] {
    CLS_UNSUPPORTED = 3'h0,
    CLS_NAN = 3'h1,
    CLS_NORMAL = 3'h2,
    CLS_INF = 3'h3,
    CLS_ZERO = 3'h4,
    CLS_EMPTY = 3'h5,
    CLS_DENORMAL = 3'h6
  } value_class_t;

  function automatic logic [6:0] lead_zeros(input logic [63:0] v);
    logic [6:0] n;
    logic found;
    n = 7'h40;
    found = 1'b0;
    for (int i = 63; i >= 0; i--)
    begin
      if (!found && v[i])
      begin
        n = 7'(63 - i);
        found = 1'b1;
      end
    end
    return n;
  endfunction : lead_zeros

endpackage : fpu_xel_pkg

/* hdl/fp_class_unit.sv */
// Combinational value classifier for one stack register.
`timescale 1ns/1ns
`default_nettype none
module fp_class_unit (
  // Operand
  input wire logic [79:0] value,
  input wire logic full,
  // Class
  output fpu_xel_pkg::value_class_t cls,
  output logic is_snan
);
  logic [14:0] exp_f;
  assign exp_f = value[fpu_xel_pkg::EXP_HI:fpu_xel_pkg::EXP_LO];

  always_comb
  begin
    if (!full)
      cls = fpu_xel_pkg::CLS_EMPTY;
    else if (exp_f == fpu_xel_pkg::EXP_MAX)
    begin
      if (!value[fpu_xel_pkg::INT_POS])
        cls = fpu_xel_pkg::CLS_UNSUPPORTED;
      else if (value[62:0] == 63'h0)
        cls = fpu_xel_pkg::CLS_INF;
      else
        cls = fpu_xel_pkg::CLS_NAN;
    end
    else if (exp_f == fpu_xel_pkg::EXP_ZERO)
      cls = (value[63:0] == 64'h0) ? fpu_xel_pkg::CLS_ZERO : fpu_xel_pkg::CLS_DENORMAL;
    else if (!value[fpu_xel_pkg::INT_POS])
      cls = fpu_xel_pkg::CLS_UNSUPPORTED;
    else
      cls = fpu_xel_pkg::CLS_NORMAL;
  end

  assign is_snan = (cls == fpu_xel_pkg::CLS_NAN) && !value[fpu_xel_pkg::QUIET_POS];
endmodule : fp_class_unit
`default_nettype wire

/* hdl/log2_mul_unit.sv */
// Combinational y times log2(x) for finite positive x and finite y.
`timescale 1ns/1ns
`default_nettype none
module log2_mul_unit (
  // Operands
  input wire logic [79:0] x,
  input wire logic [79:0] y,
  // Product
  output logic [79:0] prod
);
  logic [6:0] xlz;
  logic [6:0] ylz;
  logic [6:0] plz;
  logic [63:0] xsig;
  logic [63:0] ysig;
  logic [16:0] xe;
  logic [31:0] lval;
  logic [31:0] lmag;
  logic [63:0] pmag;
  logic [17:0] rexp;
  logic [14:0] xexp;
  logic [14:0] yexp;

  assign xexp = x[fpu_xel_pkg::EXP_HI:fpu_xel_pkg::EXP_LO];
  assign yexp = y[fpu_xel_pkg::EXP_HI:fpu_xel_pkg::EXP_LO];
  assign xlz = fpu_xel_pkg::lead_zeros(x[63:0]);
  assign ylz = fpu_xel_pkg::lead_zeros(y[63:0]);
  assign xsig = x[63:0] << xlz;
  assign ysig = y[63:0] << ylz;

  // The logarithm uses exponent plus a linear fraction, so precision is limited
  // to roughly sixteen bits; overflow and underflow of the result are not trapped.
  assign xe = ((xexp == fpu_xel_pkg::EXP_ZERO) ? fpu_xel_pkg::DENORM_TRUE_EXP
              : ({2'h0, xexp} - {2'h0, fpu_xel_pkg::EXP_BIAS})) - {10'h0, xlz};
  assign lval = {xe[15:0], xsig[62:62 - fpu_xel_pkg::LOG_FRAC_W + 1]};
  assign lmag = lval[31] ? (32'h0 - lval) : lval;
  assign pmag = lmag * ysig[63:32];
  assign plz = fpu_xel_pkg::lead_zeros(pmag);
  assign rexp = ((yexp == fpu_xel_pkg::EXP_ZERO) ? 18'h1 : {3'h0, yexp})
              - {11'h0, ylz} + 18'h10 - {11'h0, plz};

  always_comb
  begin
    if (pmag == 64'h0)
      prod = fpu_xel_pkg::POS_ZERO;
    else
      prod = {y[fpu_xel_pkg::SIGN_POS] ^ lval[31], rexp[14:0], pmag << plz};
  end
endmodule : log2_mul_unit
`default_nettype wire

/* testbench/tb.sv */
// Self-checking testbench for the stack instruction unit.
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ****************************************************************
  // Stimulus, outputs and bookkeeping
  // ****************************************************************
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic op_valid = 1'b0;
  logic [7:0] op_byte0 = fpu_xel_pkg::OPC_ESC;
  logic [7:0] op_byte1 = 8'h00;
  logic emulation_flag = 1'b0;
  logic task_switched_flag = 1'b0;
  logic invalid_mask = 1'b0;
  logic zero_divide_mask = 1'b0;
  logic denormal_mask = 1'b0;
  logic load_valid = 1'b0;
  logic [2:0] load_index = 3'h0;
  logic load_full = 1'b0;
  logic [79:0] load_data = 80'h0;
  logic [2:0] read_index = 3'h0;
  logic [79:0] read_data_q;
  logic read_full_q, condition_bit_zero_q, condition_bit_one_q;
  logic condition_bit_two_q, condition_bit_three_q, op_done_q;
  logic [2:0] stack_pointer_field_q;
  logic device_unavailable_fault_q, stack_fault_q, invalid_operand_fault_q;
  logic divide_by_zero_fault_q, denormal_operand_fault_q;
  logic [11:0] obs;
  logic [23:0] notes [$];
  logic [23:0] note;
  logic [79:0] a, b, v;
  logic [79:0] ALL = {80{1'b1}};
  logic [79:0] QN = 80'h7FFF_C000_0000_0000_0000;
  logic [79:0] cv [0:6] = '{80'h4000_4000_0000_0000_0000, 80'h7FFF_C000_0000_0000_0001,
    80'h3FFF_8000_0000_0000_0000, 80'h7FFF_8000_0000_0000_0000, 80'h0,
    80'h3FFF_8000_0000_0000_0000, 80'h0000_0000_0000_0000_0001};
  logic [79:0] fv [0:2] = '{80'h0, 80'h0000_0000_0000_0000_0001, 80'h7FFF_A000_0000_0000_0000};
  logic [4:0] fe [0:2] = '{5'h02, 5'h01, 5'h04};
  logic [79:0] lv [0:1] = '{80'h0, 80'hC000_8000_0000_0000_0000};
  logic [2:0] sp = 3'h0;
  logic [2:0] kb;
  logic s;
  integer seed = 32'hEED7;
  int bad_count = 0;
  int checks_done = 0;

  assign obs = {device_unavailable_fault_q, stack_fault_q, invalid_operand_fault_q,
    divide_by_zero_fault_q, denormal_operand_fault_q, condition_bit_three_q,
    condition_bit_two_q, condition_bit_one_q, condition_bit_zero_q, stack_pointer_field_q};

  fpu_classify_exchange_extract_log DUT (.mclk, .nrst, .op_valid, .op_byte0, .op_byte1,
    .emulation_flag, .task_switched_flag, .invalid_mask, .zero_divide_mask, .denormal_mask,
    .load_valid, .load_index, .load_full, .load_data, .read_index, .read_data_q, .read_full_q,
    .condition_bit_zero_q, .condition_bit_one_q, .condition_bit_two_q, .condition_bit_three_q,
    .stack_pointer_field_q, .op_done_q, .device_unavailable_fault_q, .stack_fault_q,
    .invalid_operand_fault_q, .divide_by_zero_fault_q, .denormal_operand_fault_q);

  always #5 mclk = ~mclk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [80:0] seen, input logic [80:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Each instruction leaves a note; masked bits are the ones left undefined.
  task automatic op(input logic [7:0] bt, input logic [11:0] e, input logic [11:0] m);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_byte1 <= bt;
    notes.push_back({m, e});
    @(posedge mclk);
    op_valid <= 1'b0;
  endtask : op

  task automatic ld(input logic [2:0] i, input logic [79:0] d, input logic f);
    @(posedge mclk);
    load_valid <= 1'b1;
    load_index <= i;
    load_data <= d;
    load_full <= f;
    @(posedge mclk);
    load_valid <= 1'b0;
  endtask : ld

  task automatic rd(input logic [2:0] i, input logic f, input logic [79:0] d, input logic [79:0] dm);
    @(posedge mclk);
    read_index <= i;
    @(posedge mclk);
    @(posedge mclk);
    chk({read_full_q, read_data_q & dm}, {f, d & dm});
  endtask : rd

  function automatic logic [79:0] rnd();
    return {1'b0, 15'h4001, 1'b1, 31'($random(seed)), 32'($random(seed))};
  endfunction : rnd

  task automatic summarize();
    if (notes.size() != 0)
      bad_count++;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  always @(posedge mclk)
    if (op_done_q === 1'b1)
    begin
      note = notes.pop_front();
      chk(81'(obs & note[23:12]), 81'(note[11:0] & note[23:12]));
    end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    for (int k = 0; k < 7; k++)
    begin
      s = 1'($random(seed));
      kb = 3'(k);
      v = cv[k] | {s, 79'h0};
      ld(3'h0, v, k != 5);
      op(8'hE5, {5'h00, kb[2:1], s, kb[0], sp}, 12'hFFF);
      rd(3'h0, k != 5, v, ALL);
    end
    for (int t = 0; t < 2; t++)
    begin
      emulation_flag <= (t == 0);
      task_switched_flag <= (t == 1);
      op(8'hC9, {5'h10, 4'h0, sp}, 12'hF87);
      rd(3'h0, 1'b1, v, ALL);
    end
    emulation_flag <= 1'b0;
    task_switched_flag <= 1'b0;
    a = rnd();
    b = rnd();
    ld(3'h0, a, 1'b1);
    ld(3'h3, b, 1'b1);
    op(8'hCB, {9'h000, sp}, 12'hF97);
    rd(3'h0, 1'b1, b, ALL);
    rd(3'h3, 1'b1, a, ALL);
    ld(3'h1, v, 1'b1);
    op(8'hC9, {9'h000, sp}, 12'hF97);
    rd(3'h1, 1'b1, b, ALL);
    op(8'hCD, {5'h08, 4'h0, sp}, 12'hF97);
    rd(3'h0, 1'b1, v, ALL);
    // Negative operand with true exponent two exercises sign and bias handling.
    a[79] = 1'b1;
    ld(3'h0, a, 1'b1);
    op(8'hF4, {9'h000, sp - 3'h1}, 12'hF87);
    sp = sp - 3'h1;
    rd(3'h0, 1'b1, {1'b1, 15'h3FFF, a[63:0]}, ALL);
    rd(3'h1, 1'b1, 80'h4000_8000_0000_0000_0000, ALL);
    for (int k = 0; k < 3; k++)
    begin
      ld(3'h0, fv[k], 1'b1);
      op(8'hF4, {fe[k], 4'h0, sp}, 12'hF87);
      rd(3'h0, 1'b1, fv[k], ALL);
    end
    zero_divide_mask <= 1'b1;
    ld(3'h0, {1'b1, 79'h0}, 1'b1);
    op(8'hF4, {9'h000, sp - 3'h1}, 12'h007);
    sp = sp - 3'h1;
    rd(3'h0, 1'b1, {1'b1, 79'h0}, ALL);
    rd(3'h1, 1'b1, fpu_xel_pkg::NEG_INF, ALL);
    zero_divide_mask <= 1'b0;
    ld(3'h7, b, 1'b1);
    op(8'hF4, {5'h08, 4'h2, sp}, 12'hF97);
    ld(3'h0, fpu_xel_pkg::POS_INF, 1'b1);
    ld(3'h1, b, 1'b1);
    op(8'hF1, {9'h000, sp + 3'h1}, 12'hF87);
    sp = sp + 3'h1;
    rd(3'h0, 1'b1, fpu_xel_pkg::POS_INF, ALL);
    rd(3'h7, 1'b0, 80'h0, 80'h0);
    ld(3'h0, 80'h7FFF_C000_0000_0000_1234, 1'b1);
    op(8'hF1, {9'h000, sp + 3'h1}, 12'hF87);
    sp = sp + 3'h1;
    rd(3'h0, 1'b1, QN, QN);
    for (int k = 0; k < 2; k++)
    begin
      ld(3'h0, lv[k], 1'b1);
      ld(3'h1, b, 1'b1);
      op(8'hF1, {5'h02 << k, 4'h0, sp}, 12'hF87);
      rd(3'h1, 1'b1, b, ALL);
    end
    // Masked denormal source: the push completes and the significand is normalised.
    denormal_mask <= 1'b1;
    ld(3'h0, fv[1], 1'b1);
    op(8'hF4, {5'h01, 4'h0, sp - 3'h1}, 12'hF87);
    sp = sp - 3'h1;
    rd(3'h0, 1'b1, 80'h3FFF_8000_0000_0000_0000, ALL);
    rd(3'h1, 1'b1, 80'hC00D_807A_0000_0000_0000, ALL);
    denormal_mask <= 1'b0;
    repeat (3) @(posedge mclk);
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    summarize();
  end
endmodule : tb
`default_nettype wire
